// File: rtl/pad_cell.sv
// one pin: input synchroniser and stop/reset gating of the drive
`timescale 1ns/1ps
module pad_cell (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic stop,
   input wire pin_mux_pkg::pad_drive_t want,
   // pin
   input wire logic pin_in,
   output pin_mux_pkg::pad_drive_t pin,
   // synchronised input value
   output logic sync_in
);
   logic meta;

   // two-stage synchroniser; meta is read only by sync_in
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta <= 1'b0;
         sync_in <= 1'b0;
      end else begin
         meta <= pin_in;
         // stop freezes the sampled value: the pin becomes an ignored input
         sync_in <= stop ? sync_in : meta;
      end
   end

   // registered drive: released while in reset and in stop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin <= '0;
      end else begin
         pin.out <= want.out;
         // R12 stop tri-states outputs
         pin.oe <= want.oe & ~stop;
      end
   end
endmodule // pad_cell

// File: rtl/pin_mux_consts.svh
// register offsets, field positions, reset values and timing counts of the pin mux
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// register byte offsets
`define OFF_PORT_FUNCTION_SELECT 12'h000
`define OFF_PORT_DIRECTION 12'h004
`define OFF_PORT_DATA 12'h008
`define OFF_TIMER0_CONTROL_STATUS 12'h00C
`define OFF_TIMER1_CONTROL_STATUS 12'h010
`define OFF_TIMER2_CONTROL_STATUS 12'h014
`define OFF_TIMER0_COMPARE 12'h018
`define OFF_TIMER1_COMPARE 12'h01C
`define OFF_TIMER2_COMPARE 12'h020
`define OFF_TIMER0_COUNT 12'h024
`define OFF_TIMER1_COUNT 12'h028
`define OFF_TIMER2_COUNT 12'h02C
`define OFF_PROC_STATE 12'h030

// timer control/status field positions
`define TCS_ENABLE 0
`define TCS_MODE_LSB 1
`define TCS_MODE_MSB 3
`define TCS_GPIO_OUT 4
`define TCS_GPIO_DATA 5
`define TCS_INT_ENABLE 6
`define TCS_EXT_CLOCK 7
`define TCS_PIN_IN 8
`define TCS_DONE 9

// reset values
`define RST_PORT_FUNCTION_SELECT 3'h0
`define RST_PORT_DIRECTION 3'h0
`define RST_TIMER_CONTROL 8'h00

// serial clock divider: bit time in core clocks
`define SERIAL_BIT_CYCLES 16'h01B2

`endif

// File: rtl/pin_mux_pkg.sv
// types shared by the pin mux design
package pin_mux_pkg;

   // timer modes held in the mode field
   typedef enum logic [2:0] {
      MODE_GPIO = 3'h0,
      MODE_TIMER = 3'h1,
      MODE_WATCHDOG = 3'h2,
      MODE_PULSE = 3'h3,
      MODE_EVENT_COUNT = 3'h4,
      MODE_MEASURE = 3'h5
   } timer_mode_t;

   // processing state of the core, driven by software
   typedef enum logic [1:0] {
      PROC_NORMAL = 2'h0,
      PROC_WAIT = 2'h1,
      PROC_STOP = 2'h2
   } proc_state_t;

   // one pad's two signals
   typedef struct packed {
      logic out;
      logic oe;
   } pad_drive_t;

endpackage : pin_mux_pkg

// File: rtl/serial_timer_pin_mux.sv
// pin mux for serial port pins and three timer pins, with APB registers
`timescale 1ns/1ps
`include "pin_mux_consts.svh"

// Functional notes
// R1 - after reset the three serial port pins are general-purpose pins.
// R2 - in general-purpose mode a port pin's direction comes from the direction register.
// R3 - the function select register picks serial or general-purpose use per port pin.
// R4 - in serial mode the receive pin feeds the serial receive shift register.
// R5 - in serial mode the transmit pin is driven from the serial transmit path.
// R6 - the serial clock pin is driven out or taken in from the other party.
// R7 - three independent timers count internal or external clocks.
// R8 - each timer can interrupt or signal its pin after a programmed count.
// R9 - event counter and measurement modes make the timer pin an input.
// R10 - watchdog, timer and pulse modes make the timer pin an output.
// R11 - timer pins come out of reset as general-purpose inputs.
// R12 - in stop an input pin is ignored and an output pin is tri-stated.
// R13 - entering or leaving wait does not change any pin.
// R14 - during reset all six pins are undriven ignored inputs.
// R15 - each port pin has one select bit and one direction bit, 1 meaning peripheral or output.
module serial_timer_pin_mux #(
   parameter int TIMER_WIDTH = 24
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // serial interface side
   input wire logic [7:0] tx_byte,
   input wire logic tx_start,
   input wire logic serial_clock_out_en,
   output logic [7:0] rx_byte,
   output logic rx_valid,
   output logic tx_busy,
   // port pins: receive, transmit, serial clock
   input wire logic [2:0] port_pin_in,
   output logic [2:0] port_pin_out,
   output logic [2:0] port_pin_oe,
   // timer pins
   input wire logic [2:0] timer_pin_in,
   output logic [2:0] timer_pin_out,
   output logic [2:0] timer_pin_oe,
   // timer interrupts
   output logic [2:0] timer_irq
);
   initial begin
      if (TIMER_WIDTH < 2 || TIMER_WIDTH > 32) $error("timer width out of range");
   end

   localparam int PIN_RX = 0;
   localparam int PIN_TX = 1;
   localparam int PIN_CLK = 2;

   logic [2:0] port_function_select_reg;
   logic [2:0] port_direction_reg;
   logic [2:0] port_data;
   logic [7:0] timer_ctrl [3];
   logic [TIMER_WIDTH-1:0] timer_cmp [3];
   logic [TIMER_WIDTH-1:0] timer_cnt [3];
   logic [2:0] timer_done;
   logic [2:0] timer_irq_raw;
   logic [2:0] clear_done;
   pin_mux_pkg::proc_state_t proc_state;
   logic stop;
   logic [2:0] port_sync;
   logic [2:0] timer_sync;
   pin_mux_pkg::pad_drive_t port_want [3];
   pin_mux_pkg::pad_drive_t port_pad [3];
   pin_mux_pkg::pad_drive_t timer_want [3];
   pin_mux_pkg::pad_drive_t timer_pad [3];
   logic wr_en;
   logic rd_en;
   logic [31:0] next_prdata;
   logic next_slverr;
   // serial engine
   logic [15:0] bit_div;
   logic bit_tick;
   logic clk_level;
   logic [9:0] tx_shift;
   logic [3:0] tx_bits;
   logic [7:0] rx_shift;
   logic [3:0] rx_bits;
   logic rx_prev;
   logic serial_rx;

   // R13 wait is not a pin control: only stop gates pads
   assign stop = (proc_state == pin_mux_pkg::PROC_STOP);
   // a write lands only at the edge that completes the transfer
   assign wr_en = psel & penable & pready & pwrite;
   assign rd_en = psel & penable & ~pwrite;

   // function select and direction registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         // R1 port pins start as gpio
         port_function_select_reg <= `RST_PORT_FUNCTION_SELECT;
         port_direction_reg <= `RST_PORT_DIRECTION;
         port_data <= 3'h0;
         proc_state <= pin_mux_pkg::PROC_NORMAL;
      end else if (wr_en) begin
         unique case (paddr)
            // R15 one select bit per pin
            `OFF_PORT_FUNCTION_SELECT: port_function_select_reg <= pwdata[2:0];
            `OFF_PORT_DIRECTION: port_direction_reg <= pwdata[2:0];
            `OFF_PORT_DATA: port_data <= pwdata[2:0];
            `OFF_PROC_STATE: proc_state <= pin_mux_pkg::proc_state_t'(pwdata[1:0]);
            default: ;
         endcase
      end
   end

   // timer control and compare registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < 3; i++) begin
            // R11 timers start as gpio inputs
            timer_ctrl[i] <= `RST_TIMER_CONTROL;
            timer_cmp[i] <= '1;
         end
      end else if (wr_en) begin
         for (int i = 0; i < 3; i++) begin
            if (paddr == `OFF_TIMER0_CONTROL_STATUS + 12'(4 * i)) timer_ctrl[i] <= pwdata[7:0];
            if (paddr == `OFF_TIMER0_COMPARE + 12'(4 * i)) timer_cmp[i] <= pwdata[TIMER_WIDTH-1:0];
         end
      end
   end

   // writing 1 to the done bit clears it
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         clear_done[i] = wr_en && (paddr == `OFF_TIMER0_CONTROL_STATUS + 12'(4 * i))
            && pwdata[`TCS_DONE];
      end
   end

   // read mux; unmapped addresses answer with pslverr
   always_comb begin
      next_prdata = 32'h0000_0000;
      next_slverr = 1'b0;
      if (paddr == `OFF_PORT_FUNCTION_SELECT) next_prdata[2:0] = port_function_select_reg;
      else if (paddr == `OFF_PORT_DIRECTION) next_prdata[2:0] = port_direction_reg;
      else if (paddr == `OFF_PORT_DATA) next_prdata[2:0] = port_sync;
      else if (paddr == `OFF_PROC_STATE) next_prdata[1:0] = proc_state;
      else if (paddr >= `OFF_TIMER0_CONTROL_STATUS && paddr <= `OFF_TIMER2_COUNT
               && paddr[1:0] == 2'h0) begin
         for (int i = 0; i < 3; i++) begin
            if (paddr == `OFF_TIMER0_CONTROL_STATUS + 12'(4 * i)) begin
               next_prdata[7:0] = timer_ctrl[i];
               next_prdata[`TCS_PIN_IN] = timer_sync[i];
               next_prdata[`TCS_DONE] = timer_done[i];
            end
            if (paddr == `OFF_TIMER0_COMPARE + 12'(4 * i))
               next_prdata[TIMER_WIDTH-1:0] = timer_cmp[i];
            if (paddr == `OFF_TIMER0_COUNT + 12'(4 * i))
               next_prdata[TIMER_WIDTH-1:0] = timer_cnt[i];
         end
      end else next_slverr = 1'b1;
   end

   // apb answer: one wait state, pready in the second access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (psel && penable && !pready) begin
         pready <= 1'b1;
         prdata <= rd_en ? next_prdata : 32'h0000_0000;
         pslverr <= next_slverr;
      end else begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end
   end

   // bit-rate divider: one-cycle enable per bit, each a half period of serial clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bit_div <= 16'h0000;
         bit_tick <= 1'b0;
      end else if (bit_div == `SERIAL_BIT_CYCLES - 16'h0001) begin
         bit_div <= 16'h0000;
         bit_tick <= 1'b1;
      end else begin
         bit_div <= bit_div + 16'h0001;
         bit_tick <= 1'b0;
      end
   end

   // R5 transmit shifter: start bit, eight data bits, stop bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_shift <= 10'h3FF;
         tx_bits <= 4'h0;
         clk_level <= 1'b0;
      end else if (tx_start && tx_bits == 4'h0) begin
         tx_shift <= {1'b1, tx_byte, 1'b0};
         tx_bits <= 4'hA;
      end else if (bit_tick) begin
         clk_level <= ~clk_level;
         if (tx_bits != 4'h0) begin
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_bits <= tx_bits - 4'h1;
         end
      end
   end

   // R4 receive shifter samples the serial receive pin
   assign serial_rx = port_function_select_reg[PIN_RX] ? port_sync[PIN_RX] : 1'b1;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_shift <= 8'h00;
         rx_bits <= 4'h0;
         rx_prev <= 1'b1;
         rx_byte <= 8'h00;
         rx_valid <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         if (bit_tick) begin
            rx_prev <= serial_rx;
            if (rx_bits == 4'h0 && rx_prev && !serial_rx) begin
               rx_bits <= 4'h9;
            end else if (rx_bits > 4'h1) begin
               rx_shift <= {serial_rx, rx_shift[7:1]};
               rx_bits <= rx_bits - 4'h1;
            end else if (rx_bits == 4'h1) begin
               rx_bits <= 4'h0;
               rx_byte <= rx_shift;
               rx_valid <= serial_rx;
            end
         end
      end
   end

   // busy flag straight from a flip-flop
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) tx_busy <= 1'b0;
      else tx_busy <= (tx_bits != 4'h0) || tx_start;
   end

   // port pin drive selection
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         // R2 gpio direction from direction register
         port_want[i].out = port_data[i];
         port_want[i].oe = port_direction_reg[i];
      end
      // R3 serial function per pin
      if (port_function_select_reg[PIN_RX]) begin
         port_want[PIN_RX].out = 1'b0;
         port_want[PIN_RX].oe = 1'b0;
      end
      if (port_function_select_reg[PIN_TX]) begin
         port_want[PIN_TX].out = tx_shift[0];
         port_want[PIN_TX].oe = 1'b1;
      end
      // R6 serial clock both ways
      if (port_function_select_reg[PIN_CLK]) begin
         port_want[PIN_CLK].out = clk_level;
         port_want[PIN_CLK].oe = serial_clock_out_en;
      end
   end

   // pads and timers
   for (genvar g = 0; g < 3; g++) begin : g_pins
      // R14 pads undriven in reset
      pad_cell u_port_pad (
         .pclk(pclk),
         .presetn(presetn),
         .stop(stop),
         .want(port_want[g]),
         .pin_in(port_pin_in[g]),
         .pin(port_pad[g]),
         .sync_in(port_sync[g])
      );
      pad_cell u_timer_pad (
         .pclk(pclk),
         .presetn(presetn),
         .stop(stop),
         .want(timer_want[g]),
         .pin_in(timer_pin_in[g]),
         .pin(timer_pad[g]),
         .sync_in(timer_sync[g])
      );
      // R7 independent timer instances
      timer_unit #(.WIDTH(TIMER_WIDTH)) u_timer (
         .pclk(pclk),
         .presetn(presetn),
         .ctrl(timer_ctrl[g]),
         .compare(timer_cmp[g]),
         .clear_done(clear_done[g]),
         .stop(stop),
         .pin_level(timer_sync[g]),
         .count(timer_cnt[g]),
         .done(timer_done[g]),
         .irq(timer_irq_raw[g]),
         .want(timer_want[g])
      );
      assign port_pin_out[g] = port_pad[g].out;
      assign port_pin_oe[g] = port_pad[g].oe;
      assign timer_pin_out[g] = timer_pad[g].out;
      assign timer_pin_oe[g] = timer_pad[g].oe;
      assign timer_irq[g] = timer_irq_raw[g];
   end
endmodule // serial_timer_pin_mux

// File: rtl/timer_unit.sv
// one timer: event counter, compare and pin direction from mode
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
module timer_unit #(
   parameter int WIDTH = 24
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic [7:0] ctrl,
   input wire logic [WIDTH-1:0] compare,
   input wire logic clear_done,
   input wire logic stop,
   // synchronised pin level
   input wire logic pin_level,
   // status
   output logic [WIDTH-1:0] count,
   output logic done,
   output logic irq,
   output pin_mux_pkg::pad_drive_t want
);
   initial begin
      if (WIDTH < 2 || WIDTH > 32) $error("timer width out of range");
   end

   pin_mux_pkg::timer_mode_t mode;
   logic enable;
   logic prev_level;
   logic tick;
   logic hit;
   logic toggle;

   assign mode = pin_mux_pkg::timer_mode_t'(ctrl[`TCS_MODE_MSB:`TCS_MODE_LSB]);
   assign enable = ctrl[`TCS_ENABLE] & ~stop;
   // R7 internal or external clock
   assign tick = ctrl[`TCS_EXT_CLOCK] ? (pin_level & ~prev_level) : 1'b1;
   assign hit = enable && tick && (count + 1'b1 == compare);

   // edge history of the pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prev_level <= 1'b0;
      else prev_level <= pin_level;
   end

   // counter restarts on compare so events repeat every compare ticks
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= '0;
      end else if (!enable) begin
         count <= count;
      end else if (hit) begin
         count <= '0;
      end else if (tick) begin
         count <= count + 1'b1;
      end
   end

   // R8 sticky done, set wins over clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) done <= 1'b0;
      else if (hit) done <= 1'b1;
      else if (clear_done) done <= 1'b0;
   end

   // R8 interrupt and pin toggle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
         toggle <= 1'b0;
      end else begin
         irq <= done & ctrl[`TCS_INT_ENABLE];
         if (hit && !ctrl[`TCS_EXT_CLOCK]) toggle <= ~toggle;
      end
   end

   // pin direction from mode
   always_comb begin
      want.out = 1'b0;
      want.oe = 1'b0;
      unique case (mode)
         // R11 gpio default input
         pin_mux_pkg::MODE_GPIO: begin
            want.out = ctrl[`TCS_GPIO_DATA];
            want.oe = ctrl[`TCS_GPIO_OUT];
         end
         // R10 output modes
         pin_mux_pkg::MODE_TIMER, pin_mux_pkg::MODE_WATCHDOG,
         pin_mux_pkg::MODE_PULSE: begin
            want.out = toggle;
            want.oe = 1'b1;
         end
         // R9 input modes
         pin_mux_pkg::MODE_EVENT_COUNT, pin_mux_pkg::MODE_MEASURE: begin
            want.oe = 1'b0;
         end
         default: want.oe = 1'b0;
      endcase
   end
endmodule // timer_unit

// File: test/pin_far_side.sv
// far-side model: serial peer and timer event sources on the six pins
`timescale 1ns/1ps
module pin_far_side (
   // bench controls
   input wire logic loop,
   input wire logic [2:0] port_drive,
   input wire logic [2:0] timer_drive,
   // device side of the pins
   input wire logic [2:0] port_pin_out,
   input wire logic [2:0] port_pin_oe,
   input wire logic [2:0] timer_pin_out,
   input wire logic [2:0] timer_pin_oe,
   output logic [2:0] port_pin_in,
   output logic [2:0] timer_pin_in
);
   logic [2:0] peer;
   // peer supplies the serial clock level when the device does not
   always_comb begin
      peer = port_drive;
      // echo transmit onto receive, idle high when transmit is released
      if (loop) peer[0] = port_pin_oe[1] ? port_pin_out[1] : 1'b1;
   end
   // the wire follows the device while it drives, the peer otherwise
   assign port_pin_in = (port_pin_oe & port_pin_out) | (~port_pin_oe & peer);
   assign timer_pin_in = (timer_pin_oe & timer_pin_out) | (~timer_pin_oe & timer_drive);
endmodule // pin_far_side

// File: test/pin_mux_sva.sv
// concurrent checks on the pin mux top-level ports
`timescale 1ns/1ps
module pin_mux_sva (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   // pin enables
   input wire logic [2:0] port_pin_oe,
   input wire logic [2:0] timer_pin_oe
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic wr;
   logic stop_q;
   logic [2:0] fsel_q;
   // a register only changes on a completed write
   assign wr = psel && penable && pready && pwrite;
   // mirrors of select and stop; pin checks mean nothing without them
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stop_q <= 1'b0;
         fsel_q <= 3'h0;
      end else if (wr) begin
         if (paddr == 12'h030) stop_q <= (pwdata[1:0] == 2'h2);
         if (paddr == 12'h000) fsel_q <= pwdata[2:0];
      end
   end
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_answer;
      !pready ##1 pready;
   endsequence
   a_ready_one_wait: assert property (s_setup |=> s_answer)
      else $error("pready not in second access cycle");
   a_slverr_with_ready: assert property (pslverr |-> pready && !$past(pready))
      else $error("pslverr outside a single pready cycle");
   a_reset_undriven: assert property (@(posedge pclk) disable iff (1'b0)
      !presetn |-> port_pin_oe == 3'h0 && timer_pin_oe == 3'h0)
      else $error("pin driven during reset");
   a_reset_gpio_in: assert property ($rose(presetn) |->
      (port_pin_oe == 3'h0 && timer_pin_oe == 3'h0)[*3])
      else $error("pin driven just after reset");
   a_dir_follows_reg: assert property (wr && paddr == 12'h004 && fsel_q == 3'h0
      && !stop_q |-> ##2 port_pin_oe == $past(pwdata[2:0], 2))
      else $error("port direction not from register");
   a_timer_in_mode: assert property (wr && paddr == 12'h00C && !stop_q
      && pwdata[3:1] inside {3'h4, 3'h5} |-> ##2 !timer_pin_oe[0])
      else $error("timer pin not input in count mode");
   a_timer_out_mode: assert property (wr && paddr == 12'h00C && !stop_q && pwdata[0]
      && pwdata[3:1] inside {3'h1, 3'h2, 3'h3} |-> ##2 timer_pin_oe[0])
      else $error("timer pin not output in timer mode");
   a_stop_tristates: assert property (wr && paddr == 12'h030
      && pwdata[1:0] == 2'h2 |-> ##2 (port_pin_oe == 3'h0 && timer_pin_oe == 3'h0))
      else $error("pins still driven after stop");
   a_stop_holds_off: assert property (stop_q && $past(stop_q) |->
      port_pin_oe == 3'h0 && timer_pin_oe == 3'h0)
      else $error("pin driven while stopped");
   a_wait_no_change: assert property (wr && paddr == 12'h030 && pwdata[1:0] == 2'h1
      && !stop_q |=> ($stable(port_pin_oe) && $stable(timer_pin_oe))[*3])
      else $error("wait changed a pin direction");
endmodule // pin_mux_sva

bind serial_timer_pin_mux pin_mux_sva i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .port_pin_oe(port_pin_oe), .timer_pin_oe(timer_pin_oe));

// File: test/test_serial_timer_pin_mux.sv
// self-checking bench for the serial and timer pin mux
`timescale 1ns/1ps
module test_serial_timer_pin_mux;
   logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata;
   logic pready, pslverr, tx_start = 1'b0, serial_clock_out_en = 1'b0, rx_valid, tx_busy;
   logic [7:0] tx_byte = 8'h00, rx_byte;
   logic [2:0] port_pin_in, port_pin_out, port_pin_oe, timer_pin_in, timer_pin_out;
   logic [2:0] timer_pin_oe, timer_irq, ext_port = 3'h0, ext_tmr = 3'h0;
   logic loop = 1'b0;
   int err_count = 0, check_count = 0, cyc = 0, dir_m, dat_m, ext_m, n;
   int rx_q[$];
   serial_timer_pin_mux i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .tx_byte(tx_byte), .tx_start(tx_start),
      .serial_clock_out_en(serial_clock_out_en), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .tx_busy(tx_busy), .port_pin_in(port_pin_in), .port_pin_out(port_pin_out),
      .port_pin_oe(port_pin_oe), .timer_pin_in(timer_pin_in), .timer_pin_out(timer_pin_out),
      .timer_pin_oe(timer_pin_oe), .timer_irq(timer_irq));
   pin_far_side i_far (.loop(loop), .port_drive(ext_port), .timer_drive(ext_tmr),
      .port_pin_out(port_pin_out), .port_pin_oe(port_pin_oe), .timer_pin_out(timer_pin_out),
      .timer_pin_oe(timer_pin_oe), .port_pin_in(port_pin_in), .timer_pin_in(timer_pin_in));
   // 50 MHz clock
   always #10 pclk = ~pclk;
   task automatic report_and_stop();
      if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // cut a hang short; the whole run needs about 10000 cycles
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] r, output logic s);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // only the bench timeout ends this wait
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      r = prdata;
      s = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input int d);
      logic [31:0] r;
      logic s;
      apb(1'b1, a, 32'(d), r, s);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic es, string nm);
      logic [31:0] r;
      logic s;
      apb(1'b0, a, 32'h0, r, s);
      chk(nm, e, r);
      chk("pslverr", {31'h0, es}, {31'h0, s});
   endtask
   task automatic settle(input int k);
      repeat (k) @(posedge pclk);
      @(negedge pclk);
   endtask
   initial begin
      void'($urandom(32'hA792));
      // a real falling edge so the asynchronous resets take hold
      presetn <= 1'b0;
      repeat (10) @(posedge pclk);
      chk("oe_rst", 32'h0, {26'h0, port_pin_oe, timer_pin_oe});
      presetn <= 1'b1;
      @(negedge pclk);
      chk("oe_init", 32'h0, {26'h0, port_pin_oe, timer_pin_oe});
      rd(12'h000, 32'h0, 1'b0, "fsel");
      rd(12'h004, 32'h0, 1'b0, "dir");
      rd(12'h040, 32'h0, 1'b1, "unmapped");
      // random directions and levels in general-purpose mode
      repeat (6) begin
         dir_m = $urandom_range(7);
         dat_m = $urandom_range(7);
         ext_m = $urandom_range(7);
         wr(12'h004, dir_m);
         wr(12'h008, dat_m);
         ext_port <= 3'(ext_m);
         settle(3);
         chk("port_oe", 32'(dir_m), {29'h0, port_pin_oe});
         chk("port_out", 32'(dir_m & dat_m), {29'h0, port_pin_oe & port_pin_out});
         rd(12'h008, 32'((dir_m & dat_m) | (~dir_m & ext_m & 7)), 1'b0, "port_in");
      end
      // short compare first: the mode sweep leaves timer 0 counting
      wr(12'h018, 6);
      // modes 1 to 5 on every timer: count modes in, timing modes out
      for (int t = 0; t < 3; t++)
         for (int m = 1; m < 6; m++) begin
            wr(12'h00C + 12'(4 * t), m * 2 + 1);
            settle(2);
            chk("tmr_oe", 32'(m < 4), {31'h0, timer_pin_oe[t]});
         end
      // short compare with interrupt enabled
      wr(12'h00C, 32'h43);
      n = 0;
      while (timer_irq[0] !== 1'b1 && n < 200) begin
         @(posedge pclk);
         n++;
      end
      chk("irq", 32'h1, {31'h0, timer_irq[0]});
      wr(12'h00C, 32'h200);
      settle(2);
      chk("irq_off", 32'h0, {31'h0, timer_irq[0]});
      // serial mode on all three pins, transmit looped back to receive
      loop <= 1'b1;
      serial_clock_out_en <= 1'b1;
      wr(12'h000, 7);
      settle(2);
      chk("ser_oe", 32'h6, {29'h0, port_pin_oe});
      serial_clock_out_en <= 1'b0;
      settle(2);
      chk("ser_oe_clk_in", 32'h2, {29'h0, port_pin_oe});
      repeat (2) begin
         @(posedge pclk);
         tx_byte <= 8'($urandom_range(255));
         tx_start <= 1'b1;
         @(posedge pclk);
         tx_start <= 1'b0;
         rx_q.push_back(int'(tx_byte));
         n = 0;
         while (rx_valid !== 1'b1 && n < 6000) begin
            @(posedge pclk);
            n++;
         end
         chk("rx_byte", 32'(rx_q.pop_front()), {24'h0, rx_byte});
         while (tx_busy !== 1'b0 && n < 6000) begin
            @(posedge pclk);
            n++;
         end
      end
      // wait keeps pins, stop releases outputs and freezes inputs
      loop <= 1'b0;
      wr(12'h000, 0);
      wr(12'h004, 3);
      wr(12'h008, 5);
      wr(12'h010, 3);
      ext_m = $urandom_range(7);
      ext_port <= 3'(ext_m);
      settle(3);
      rd(12'h008, 32'(1 | (ext_m & 4)), 1'b0, "pre_stop");
      wr(12'h030, 1);
      settle(2);
      chk("wait_oe", 32'h1A, {26'h0, port_pin_oe, timer_pin_oe});
      wr(12'h030, 2);
      settle(2);
      chk("stop_oe", 32'h0, {26'h0, port_pin_oe, timer_pin_oe});
      ext_port <= ~3'(ext_m);
      settle(3);
      rd(12'h008, 32'(1 | (ext_m & 4)), 1'b0, "stop_in");
      wr(12'h030, 0);
      settle(2);
      chk("resume_oe", 32'h1A, {26'h0, port_pin_oe, timer_pin_oe});
      report_and_stop();
   end
endmodule // test_serial_timer_pin_mux
